// ### rtl/asr_ctrl.sv
`timescale 1ns/1ps
module asr_ctrl #(
  parameter int POWER_UP_CYC = asr_pkg::ASR_POWER_UP_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic                         req_write,
  input  wire logic [asr_pkg::ASR_ADDR_W-1:0] req_addr,
  input  wire logic [asr_pkg::ASR_DATA_W-1:0] req_wdata,
  input  wire logic [1:0]                   req_lanes,
  output logic                              rsp_valid,
  output logic [asr_pkg::ASR_DATA_W-1:0]    rsp_rdata,
  output logic                              chip_select_n,
  output logic                              write_strobe_n,
  output logic                              output_enable_n,
  output logic                              lower_lane_enable_n,
  output logic                              upper_lane_enable_n,
  output logic [asr_pkg::ASR_ADDR_W-1:0]    word_address,
  output logic [asr_pkg::ASR_DATA_W-1:0]    data_bus_out,
  output logic                              data_bus_oe,
  input  wire logic [asr_pkg::ASR_DATA_W-1:0] data_bus_in
);
  import asr_pkg::*;

  asr_tmr_if tif ();                      // Interval timer link.
  asr_state_type state_ff;                // Present state.
  asr_state_type nxt_state;               // Next state.
  logic [17:0] addr_ff;                   // Held address pins.
  logic [15:0] wdata_ff;                  // Held write data.
  logic [1:0]  lanes_ff;                  // Held lane enables, active high.
  logic        cs_ff;                     // Chip select, active high.
  logic        we_ff;                     // Write strobe, active high.
  logic        oe_ff;                     // Output enable, active high.
  logic        drive_ff;                  // Controller drives data bus.
  logic        rsp_ff;                    // Read answer pulse.
  logic [15:0] rdata_ff;                  // Captured read word.
  logic [15:0] sync1_ff;                  // First synchroniser stage.
  logic [15:0] sync2_ff;                  // Second synchroniser stage.
  logic        take;                      // Request accepted this cycle.
  logic [11:0] pu_cyc;                    // Power-up wait as a count.
  logic [15:0] lane_mask;                 // Bits of enabled lanes.
  logic        pu_load_ff;                // Starts the power-up wait.
  logic        pu_read_ff;                // Pending read capture.

  // Sizes the power-up parameter to the timer; the default must fit.
  assign pu_cyc    = 12'(POWER_UP_CYC);
  assign take      = req_valid && req_ready;
  assign req_ready = (state_ff == ASR_IDLE) && tif.done;
  assign lane_mask = {{8{lanes_ff[1]}}, {8{lanes_ff[0]}}};

  asr_timer u_tmr (
    .mclk (mclk),
    .rst_n(rst_n),
    .tmr  (tif.tmr)
  );

  // Next state: each phase but idle ends when its timed interval has elapsed; idle ends on an accepted request.
  always_comb begin
    nxt_state = state_ff;
    tif.load  = 1'b0;
    tif.count = ASR_CNT_ZERO;
    unique case (state_ff)
      ASR_POWERUP: begin
        if (pu_load_ff) begin
          // The timer leaves reset at zero, so the wait must be loaded.
          tif.load  = 1'b1;
          tif.count = pu_cyc;
        end else if (tif.done) begin
          nxt_state = ASR_IDLE;
        end
      end
      ASR_IDLE: begin
        if (take) begin
          tif.load  = 1'b1;
          // Whole cycles, rounded up, cover every minimum.
          tif.count = req_write ? 12'(ASR_WRITE_CYC)
                                : 12'(ASR_READ_CYC);
          nxt_state = req_write ? ASR_WRITE : ASR_READ;
        end
      end
      ASR_WRITE: begin
        if (tif.done) begin
          tif.load  = 1'b1;
          tif.count = 12'(ASR_FLOAT_CYC);
          nxt_state = ASR_RELEASE;
        end
      end
      ASR_READ: begin
        if (tif.done) begin
          // Lanes need turnaround time before anyone drives again.
          tif.load  = 1'b1;
          tif.count = 12'(ASR_FLOAT_CYC);
          nxt_state = ASR_RELEASE;
        end
      end
      ASR_RELEASE: begin
        if (tif.done) begin
          nxt_state = ASR_IDLE;
        end
      end
      default: begin
        nxt_state = ASR_IDLE;
      end
    endcase
  end

  // Power-up interval is loaded by a one-shot after reset release.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pu_load_ff <= 1'b1;
    end else begin
      pu_load_ff <= 1'b0;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= ASR_POWERUP;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address, data and lanes are latched with the request and held
  // through the whole access, so setup is full; address hold is generous, but data drive and lane enables end at the write end edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_ff  <= ASR_ADDR_ZERO;
      wdata_ff <= ASR_DATA_ZERO;
      lanes_ff <= 2'b00;
    end else if (take) begin
      addr_ff  <= req_addr;
      wdata_ff <= req_wdata;
      lanes_ff <= req_lanes;
    end
  end

  // Strobes. Select and write strobe rise together at write end, so
  // the terminating edge is common and all setups measure against it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_ff    <= 1'b0;
      we_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      drive_ff <= 1'b0;
    end else begin
      cs_ff    <= (nxt_state == ASR_WRITE) ||
                  (nxt_state == ASR_READ);
      we_ff    <= (nxt_state == ASR_WRITE);
      oe_ff    <= (nxt_state == ASR_READ);
      drive_ff <= (nxt_state == ASR_WRITE);
    end
  end

  // Read data passes two flops; the word sampled one cycle into the
  // read phase was stable for the whole access window.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_ff <= ASR_DATA_ZERO;
      sync2_ff <= ASR_DATA_ZERO;
      rdata_ff <= ASR_DATA_ZERO;
      rsp_ff   <= 1'b0;
    end else begin
      sync1_ff <= data_bus_in;
      sync2_ff <= sync1_ff;
      // Capture one cycle into release so the sample is past two flops.
      rsp_ff   <= (state_ff == ASR_RELEASE) && pu_read_ff;
      if ((state_ff == ASR_RELEASE) && pu_read_ff) begin
        rdata_ff <= sync2_ff & lane_mask;
      end
    end
  end

  // Remembers that the access in release was a read, for one capture.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pu_read_ff <= 1'b0;
    end else begin
      pu_read_ff <= (state_ff == ASR_READ) && tif.done;
    end
  end

  // Pin and answer outputs, all from flops.
  assign chip_select_n       = !cs_ff;
  assign write_strobe_n      = !we_ff;
  assign output_enable_n     = !oe_ff;
  assign lower_lane_enable_n = !(cs_ff && lanes_ff[0]);
  assign upper_lane_enable_n = !(cs_ff && lanes_ff[1]);
  assign word_address        = addr_ff;
  assign data_bus_out        = wdata_ff;
  assign data_bus_oe         = drive_ff;
  assign rsp_valid           = rsp_ff;
  assign rsp_rdata           = rdata_ff;

  // Trade-off: a single shared timer keeps area small at the cost of
  // serialising every phase.

  AST_WE_NEEDS_CS: assert property (@(posedge mclk) disable iff (!rst_n)
    !write_strobe_n |-> !chip_select_n)
    else $error("Write strobe low without chip select.");
  AST_NO_CONTENTION: assert property (@(posedge mclk) disable iff (!rst_n)
    data_bus_oe |-> output_enable_n)
    else $error("Bus driven while device outputs enabled.");
  AST_READ_WE_HIGH: assert property (@(posedge mclk) disable iff (!rst_n)
    !output_enable_n |-> write_strobe_n && !chip_select_n)
    else $error("Read without select or with strobe low.");
  AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    !write_strobe_n && !$rose(write_strobe_n) |=> $stable(word_address))
    else $error("Address moved during write.");
  AST_DATA_DRIVEN: assert property (@(posedge mclk) disable iff (!rst_n)
    !write_strobe_n |-> data_bus_oe)
    else $error("Write data not driven during write.");
  AST_NO_EARLY: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> chip_select_n [*8])
    else $error("Access during power-up wait.");
  AST_STANDBY: assert property (@(posedge mclk) disable iff (!rst_n)
    chip_select_n |-> write_strobe_n && output_enable_n)
    else $error("Strobes active while deselected.");
  AST_RSP_AFTER_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    rsp_valid |-> $past(output_enable_n) && !req_ready)
    else $error("Answer out of sequence.");
  AST_READ_LONG: assert property (@(posedge mclk) disable iff (!rst_n)
    rsp_valid |-> !$past(output_enable_n, 2) && !$past(output_enable_n, 3))
    else $error("Answer without a two-cycle read window.");
  COV_WRITE: cover property (@(posedge mclk) $rose(write_strobe_n));
  COV_READ: cover property (@(posedge mclk) rsp_valid);
  COV_B2B: cover property (@(posedge mclk) take ##[1:20] take);
endmodule

// ### rtl/asr_pkg.sv
package asr_pkg;
  // Memory geometry.
  localparam int ASR_ADDR_W = 18;
  localparam int ASR_DATA_W = 16;
  localparam int ASR_CLK_PERIOD_NS = 100;
  // Timing figures in ns, power-up wait in us (slower grade where two are given).
  localparam int ASR_ADDRESS_ACCESS_TIME_NS = 12;
  localparam int ASR_ADDRESS_CHANGE_DATA_HOLD_NS = 3;
  localparam int ASR_LANE_ENABLE_ACCESS_TIME_NS = 6;
  localparam int ASR_LANE_DISABLE_FLOAT_TIME_NS = 6;
  localparam int ASR_ADDRESS_SETUP_TO_WRITE_END_NS = 8;
  localparam int ASR_DATA_SETUP_TO_WRITE_END_NS = 6;
  localparam int ASR_LANE_ENABLE_TO_WRITE_END_NS = 8;
  localparam int ASR_WRITE_STROBE_FLOAT_TIME_NS = 6;
  localparam int ASR_POWER_UP_WAIT_US = 100;
  // Minimum intervals round up to whole clocks, never below one.
  function automatic int asr_cyc_up(input int ns);
    int c;
    c = (ns + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // Read wait covers the address access time only.
  localparam int ASR_READ_CYC = asr_cyc_up(ASR_ADDRESS_ACCESS_TIME_NS);
  // Write pulse covers data setup plus write strobe float.
  localparam int ASR_WRITE_CYC = asr_cyc_up(
    ASR_WRITE_STROBE_FLOAT_TIME_NS + ASR_DATA_SETUP_TO_WRITE_END_NS);
  // Bus turnaround after the device releases the lanes.
  localparam int ASR_FLOAT_CYC = asr_cyc_up(ASR_LANE_DISABLE_FLOAT_TIME_NS);
  localparam int ASR_POWER_UP_CYC =
    (ASR_POWER_UP_WAIT_US * 1000) / ASR_CLK_PERIOD_NS;
  localparam logic [11:0] ASR_CNT_ZERO = 12'h000;
  localparam logic [15:0] ASR_DATA_ZERO = 16'h0000;
  localparam logic [17:0] ASR_ADDR_ZERO = 18'h00000;
  // Controller states.
  typedef enum logic [2:0] {
    ASR_POWERUP = 3'b000,
    ASR_IDLE    = 3'b001,
    ASR_WRITE   = 3'b010,
    ASR_READ    = 3'b011,
    ASR_RELEASE = 3'b100
  } asr_state_type;
endpackage

// ### rtl/asr_tmr_if.sv
`timescale 1ns/1ps
// Carries the interval timer load and expiry between the controller and
// its counter.
interface asr_tmr_if;
  logic        load;  // Start a new interval.
  logic [11:0] count; // Interval length in cycles.
  logic        done;  // Interval elapsed.
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ### rtl/asr_timer.sv
`timescale 1ns/1ps
// Down counter that flags when a loaded interval of cycles has elapsed.
module asr_timer (
  input wire logic mclk,
  input wire logic rst_n,
  asr_tmr_if.tmr   tmr
);
  import asr_pkg::*;
  logic [11:0] cnt_ff;     // Cycles still to wait.
  logic [11:0] nxt_cnt;    // Next count.
  // Load wins over counting; count stops at zero.
  assign nxt_cnt = tmr.load ? tmr.count :
                   (cnt_ff != ASR_CNT_ZERO) ? cnt_ff - 12'h001 : cnt_ff;
  // Done looks only at the count, so a load decided from done cannot
  // feed back into done within the same cycle.
  assign tmr.done = (cnt_ff == ASR_CNT_ZERO);
  // Counter register.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= ASR_CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

// ### test/asr_sram_model.sv
`timescale 1ns/1ps
// Behavioural static memory on the far side of the controller pins.
module asr_sram_model (
  input  wire logic        cs_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        lo_n,
  input  wire logic        hi_n,
  input  wire logic [17:0] addr,
  input  wire logic [15:0] ctl_d,
  input  wire logic        ctl_oe,
  output logic      [15:0] bus,
  output logic             drv_lo,
  output logic             drv_hi
);
  import asr_pkg::*;
  logic [15:0] mem [0:262143]; // Whole word array.
  logic [15:0] rd_q;           // Stored word after the access delay.
  logic        rd_ok;          // Selected read with outputs enabled.
  logic        wr_on;          // Select and write strobe overlap low.
  logic [15:0] bus_d;          // Bus word just before the last edge.
  logic [17:0] addr_d;         // Address just before the last edge.
  logic        lo_d;           // Lower lane enable just before the edge.
  logic        hi_d;           // Upper lane enable just before the edge.
  // Deselect, a write or disabled outputs leave both lanes floating.
  assign rd_ok = !cs_n && !oe_n && we_n;
  // Lanes switch on and off within the lane delays.
  assign #(ASR_LANE_ENABLE_ACCESS_TIME_NS)
    drv_lo = rd_ok && !lo_n;
  assign #(ASR_LANE_ENABLE_ACCESS_TIME_NS)
    drv_hi = rd_ok && !hi_n;
  // Inertial delay keeps old data past an address change.
  assign #(ASR_ADDRESS_ACCESS_TIME_NS) rd_q = mem[addr];
  // A floating lane shows the inverse word, so a late sample is wrong.
  assign bus[7:0]  = ctl_oe ? ctl_d[7:0] : drv_lo ? rd_q[7:0] : ~rd_q[7:0];
  assign bus[15:8] = ctl_oe ? ctl_d[15:8] : drv_hi ? rd_q[15:8] : ~rd_q[15:8];
  // The write lasts while select and strobe overlap low.
  assign wr_on = !cs_n && !we_n;
  // Data, lanes and strobes may all drop at the same edge, since no data
  // hold is needed; copies lagging by one nanosecond avoid that race.
  assign #1 bus_d  = bus;
  assign #1 addr_d = addr;
  assign #1 lo_d   = lo_n;
  assign #1 hi_d   = hi_n;
  // The word is stored at the edge that ends the overlap.
  always @(negedge wr_on) begin
    if (lo_d === 1'b0) begin
      mem[addr_d][7:0] = bus_d[7:0];
    end
    if (hi_d === 1'b0) begin
      mem[addr_d][15:8] = bus_d[15:8];
    end
  end
endmodule

// ### test/testbench.sv
`timescale 1ns/1ps
// Drives requests from a table, then resets mid-run.
module testbench;
  import asr_pkg::*;
  localparam int PWR = 8; // Shortened power-up wait.
  typedef struct packed {
    logic w; logic [17:0] a; logic [15:0] d; logic [1:0] l; logic [15:0] e;
  } asr_row_type;
  logic        mclk, rst_n, req_valid, req_ready, req_write, rsp_valid;
  logic [17:0] req_addr, word_address;
  logic [15:0] req_wdata, rsp_rdata, data_bus_out, data_bus_in;
  logic [1:0]  req_lanes;
  logic        cs_n, we_n, oe_n, lo_n, hi_n, data_bus_oe, drv_lo, drv_hi;
  int          miscompares, num_checks, cyc, up_cnt, n;
  // Write rows carry no expected word; read words are lane masked.
  asr_row_type rows [11] = '{
    '{1'h1, 18'h00000, 16'hA5C3, 2'h3, 16'h0000},
    '{1'h1, 18'h3FFFF, 16'h1234, 2'h3, 16'h0000},
    '{1'h0, 18'h00000, 16'h0000, 2'h3, 16'hA5C3},
    '{1'h0, 18'h3FFFF, 16'h0000, 2'h3, 16'h1234},
    '{1'h1, 18'h00000, 16'h7E5A, 2'h1, 16'h0000},
    '{1'h1, 18'h00000, 16'hBBCC, 2'h2, 16'h0000},
    '{1'h0, 18'h00000, 16'h0000, 2'h3, 16'hBB5A},
    '{1'h0, 18'h00000, 16'h0000, 2'h1, 16'h005A},
    '{1'h0, 18'h00000, 16'h0000, 2'h2, 16'hBB00},
    '{1'h1, 18'h3FFFF, 16'hFFFF, 2'h0, 16'h0000},
    '{1'h0, 18'h3FFFF, 16'h0000, 2'h3, 16'h1234}};
  asr_ctrl #(.POWER_UP_CYC(PWR)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_select_n(cs_n), .write_strobe_n(we_n),
    .output_enable_n(oe_n), .lower_lane_enable_n(lo_n),
    .upper_lane_enable_n(hi_n), .word_address(word_address),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .data_bus_in(data_bus_in));
  asr_sram_model mem_u (
    .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .lo_n(lo_n), .hi_n(hi_n),
    .addr(word_address), .ctl_d(data_bus_out), .ctl_oe(data_bus_oe),
    .bus(data_bus_in), .drv_lo(drv_lo), .drv_hi(drv_hi));
  initial mclk = 1'h0;
  always #50 mclk = ~mclk;
  // Counts cycles since reset release and cuts a hang short.
  always @(posedge mclk) begin
    up_cnt <= !rst_n ? 0 : up_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  // Pin watch: no early access, no fight on the data wires.
  always @(negedge mclk) begin
    if (rst_n === 1'h1) begin
      if (up_cnt < PWR) check(cs_n, 1'h1);
      check(data_bus_oe && (drv_lo || drv_hi), 1'h0);
    end
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Holds reset three cycles; the pins must sit idle by its end.
  task automatic do_reset();
    rst_n = 1'h0;
    repeat (3) @(negedge mclk);
    check({cs_n, we_n, oe_n, data_bus_oe, rsp_valid}, 5'h1C);
    rst_n = 1'h1;
    @(negedge mclk);
    check(req_ready, 1'h0);
  endtask
  // Offers one request, checks the pins during the strobe phase.
  task automatic op(input asr_row_type r, input bit wait_done);
    req_valid = 1'h1;
    req_write = r.w;
    req_addr = r.a;
    req_wdata = r.d;
    req_lanes = r.l;
    for (n = 0; n < 40 && req_ready !== 1'h1; n++) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    req_valid = 1'h0;
    check(req_ready, 1'h0);
    if (!wait_done) return;
    for (n = 0; n < 12; n++) begin
      if ((r.w ? req_ready : rsp_valid) === 1'h1) break;
      if (cs_n === 1'h0) begin
        check(word_address, r.a);
        check({hi_n, lo_n}, {~r.l[1], ~r.l[0]});
        check(we_n, !r.w);
        if (r.w) check(data_bus_out, r.d);
        if (r.w) check(data_bus_oe, 1'h1);
      end
      @(negedge mclk);
    end
    check(r.w ? req_ready : rsp_valid, 1'h1);
    if (!r.w) begin
      check(rsp_rdata, r.e);
      @(negedge mclk);
      check(rsp_valid, 1'h0);
    end
  endtask
  initial begin
    rst_n = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 18'h00000;
    req_wdata = 16'h0000;
    req_lanes = 2'h0;
    miscompares = 0;
    num_checks = 0;
    cyc = 0;
    @(negedge mclk);
    do_reset();
    foreach (rows[i]) op(rows[i], 1'b1);
    // Reset in mid-read: the word stored at 18'h3FFFF must survive it.
    op(rows[2], 1'b0);
    do_reset();
    op(rows[10], 1'b1);
    end_sim();
  end
endmodule
